// ---- common/prot_pkg.sv ----
// shared constants, field layouts and carrier types of the page relocation block
package prot_pkg;

  // geometry
  localparam int PAGES      = 8;
  localparam int SETS       = 2;
  localparam int ENTRIES    = PAGES * SETS;
  localparam int VA_W       = 16;
  localparam int PA_W       = 18;
  localparam int BASE_W     = 12;
  localparam int LEN_W      = 7;
  localparam int KEY_W      = 2;
  localparam int MODE_W     = 2;
  localparam int PAGE_W     = 3;
  localparam int IDX_W      = 4;
  localparam int OFFSET_W   = 6;
  localparam int CAUSE_W    = 3;
  localparam int DATA_W     = 32;
  localparam int BE_W       = 4;
  localparam int ADDR_W     = 8;
  localparam int LANE_W     = 8;

  // virtual address fields
  localparam int VA_PAGE_LSB  = 13;
  localparam int VA_BLOCK_LSB = 6;
  localparam int VA_OFF_LSB   = 0;

  // register map: region in byte address bits 7:6, entry in bits 5:2
  localparam int REGION_LSB = 6;
  localparam int REGION_W   = 2;
  localparam int ENTRY_LSB  = 2;
  localparam logic [REGION_W-1:0] REGION_BASE   = 2'h0;
  localparam logic [REGION_W-1:0] REGION_DESC   = 2'h1;
  localparam logic [REGION_W-1:0] REGION_STATUS = 2'h2;
  localparam logic [IDX_W-1:0]    STATUS_ENTRY  = 4'h0;

  // page descriptor layout
  localparam int DESC_KEY_LSB = 1;
  localparam int DESC_DIR_BIT = 3;
  localparam int DESC_W_BIT   = 6;
  localparam int DESC_LEN_LSB = 8;

  // abort status layout
  localparam int STAT_EN_BIT    = 0;
  localparam int STAT_PAGE_LSB  = 1;
  localparam int STAT_MODE_LSB  = 5;
  localparam int STAT_CAUSE_LSB = 13;
  localparam int CAUSE_RO       = 0;
  localparam int CAUSE_PL       = 1;
  localparam int CAUSE_NR       = 2;

  // access keys and modes
  localparam logic [KEY_W-1:0]  KEY_NONRES   = 2'h0;
  localparam logic [KEY_W-1:0]  KEY_READONLY = 2'h1;
  localparam logic [KEY_W-1:0]  KEY_UNUSED   = 2'h2;
  localparam logic [KEY_W-1:0]  KEY_RDWR     = 2'h3;
  localparam logic [MODE_W-1:0] MODE_KERNEL  = 2'h0;
  localparam logic [MODE_W-1:0] MODE_USER    = 2'h3;

  typedef struct packed {
    logic [LEN_W-1:0] len;
    logic             written;
    logic             dir;
    logic [KEY_W-1:0] key;
  } desc_t;

  // reference from the processor core
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [MODE_W-1:0] mode;
    logic [VA_W-1:0]   vaddr;
  } ref_req_t;

  // reference toward the system bus
  typedef struct packed {
    logic               valid;
    logic               write;
    logic               abort;
    logic [CAUSE_W-1:0] cause;
    logic [PA_W-1:0]    paddr;
  } bus_ref_t;

endpackage

// ---- rtl/page_relocation_protection.sv ----
// page relocation and protection unit with an avalon-mm register slave
//
// How it works
// RULE_01: each descriptor keeps a software-written two-bit access key in bits 2:1.
// RULE_02: an aborted reference never reaches the bus, neither stored nor read.
// RULE_03: any modifying reference from the core counts as a write.
// RULE_04: key 00 and 10 abort all, 01 read-only, 11 read/write.
// RULE_05: read-only pages allow reads and fetches and abort every write.
// RULE_06: read/write pages allow everything with no abort from the key.
// RULE_07: descriptor bit 3 picks upward (0) or downward (1) expansion.
// RULE_08: descriptor bit 6 is set by hardware on a write; software cannot set it.
// RULE_09: writing a page's base or descriptor register clears its written flag.
// RULE_10: descriptor bits 14:8 hold a software-written length in 32-word blocks.
// RULE_11: descriptor bit 15 is unused and reads zero.
// RULE_12: upward pages abort when virtual block exceeds the length field.
// RULE_13: software loads upward lengths with one less than the block count.
// RULE_14: software loads downward lengths with 200 octal minus the block count.
// RULE_15: downward pages abort when virtual block is below the length field.
// RULE_16: top three virtual address bits pick one of eight pairs in a set.
// RULE_17: low 13 bits split into seven-bit block and six-bit offset.
// RULE_18: the current mode picks the register set before the page pair.
// RULE_19: the 12-bit base field is the page's lowest physical block.
// RULE_20: physical block is virtual block plus base block.
// RULE_21: offset is appended below the physical block giving 18 address bits.
// RULE_22: while enabled the bus sees only the translated address.
// RULE_23: mode 00 kernel set, 11 user set, 01 and 10 abort all.
// RULE_24: enable bit 0 of status gates translation and checking entirely.
// RULE_25: status bits 15,14,13 record non-resident, length and read-only aborts.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module page_relocation_protection #(
  parameter int ENTRIES = prot_pkg::ENTRIES
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           srst,
  // avalon-mm register slave
  input  wire logic [prot_pkg::ADDR_W-1:0]    address,
  input  wire logic                           read,
  input  wire logic                           write,
  input  wire logic [prot_pkg::DATA_W-1:0]    writedata,
  input  wire logic [prot_pkg::BE_W-1:0]      byteenable,
  output var  logic [prot_pkg::DATA_W-1:0]    readdata,
  output var  logic                           waitrequest,
  // processor reference in, bus reference out
  input  wire prot_pkg::ref_req_t             ref_req,
  output var  prot_pkg::bus_ref_t             bus_ref
);

  typedef struct packed {
    logic [ENTRIES-1:0][prot_pkg::BASE_W-1:0] base;
    prot_pkg::desc_t [ENTRIES-1:0]            desc;
    logic                                     enable;
    logic [prot_pkg::CAUSE_W-1:0]             cause;
    logic [prot_pkg::MODE_W-1:0]              abort_mode;
    logic [prot_pkg::PAGE_W-1:0]              abort_page;
    logic                                     waitreq;
    logic [prot_pkg::DATA_W-1:0]              rdata;
    prot_pkg::bus_ref_t                       out;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // register decode
  logic [prot_pkg::REGION_W-1:0] region;
  logic [prot_pkg::IDX_W-1:0]    entry;
  logic                          accept_wr;

  // reference decode
  logic                          mode_bad;
  logic                          user_set;
  logic [prot_pkg::PAGE_W-1:0]   page;
  logic [prot_pkg::LEN_W-1:0]    vblock;
  logic [prot_pkg::OFFSET_W-1:0] voff;
  logic [prot_pkg::IDX_W-1:0]    ref_idx;
  prot_pkg::desc_t               cur_desc;
  logic [prot_pkg::BASE_W-1:0]   cur_base;
  logic [prot_pkg::BASE_W-1:0]   pblock;
  logic                          flt_nr;
  logic                          flt_pl;
  logic                          flt_ro;
  logic                          flt_any;
  logic [prot_pkg::CAUSE_W-1:0]  flt_vec;

  assign readdata    = s_r.rdata;
  assign waitrequest = s_r.waitreq;
  assign bus_ref     = s_r.out;

  assign region    = address[prot_pkg::REGION_LSB +: prot_pkg::REGION_W];
  assign entry     = address[prot_pkg::ENTRY_LSB +: prot_pkg::IDX_W];
  assign accept_wr = write && !s_r.waitreq;

  // RULE_16 page select and RULE_17 block and offset split
  assign page   = ref_req.vaddr[prot_pkg::VA_PAGE_LSB +: prot_pkg::PAGE_W];
  assign vblock = ref_req.vaddr[prot_pkg::VA_BLOCK_LSB +: prot_pkg::LEN_W];
  assign voff   = ref_req.vaddr[prot_pkg::VA_OFF_LSB +: prot_pkg::OFFSET_W];

  // RULE_23 mode legality
  assign mode_bad = (ref_req.mode != prot_pkg::MODE_KERNEL) &&
                    (ref_req.mode != prot_pkg::MODE_USER);
  // RULE_18 set chosen by mode
  assign user_set = (ref_req.mode == prot_pkg::MODE_USER);
  assign ref_idx  = {user_set, page};
  assign cur_desc = s_r.desc[ref_idx];
  assign cur_base = s_r.base[ref_idx];

  // RULE_19 base is a block number, RULE_20 block add
  assign pblock = cur_base + prot_pkg::BASE_W'(vblock);

  // RULE_04 key decode, non-resident and unused keys abort everything
  assign flt_nr = mode_bad ||
                  (cur_desc.key == prot_pkg::KEY_NONRES) ||
                  (cur_desc.key == prot_pkg::KEY_UNUSED);
  // RULE_12 upward length check, RULE_15 downward length check
  assign flt_pl = !mode_bad &&
                  (cur_desc.dir ? (vblock < cur_desc.len) : (vblock > cur_desc.len));
  // RULE_05 read-only aborts writes, RULE_03 modify counts as write
  assign flt_ro = !mode_bad && ref_req.write && (cur_desc.key == prot_pkg::KEY_READONLY);
  assign flt_any = flt_nr || flt_pl || flt_ro;

  always_comb begin
    flt_vec = '0;
    flt_vec[prot_pkg::CAUSE_NR] = flt_nr;
    flt_vec[prot_pkg::CAUSE_PL] = flt_pl;
    flt_vec[prot_pkg::CAUSE_RO] = flt_ro;
  end

  // register readback image
  function automatic logic [prot_pkg::DATA_W-1:0] read_word(
    input state_t                         s,
    input logic [prot_pkg::REGION_W-1:0]  rg,
    input logic [prot_pkg::IDX_W-1:0]     en
  );
    logic [prot_pkg::DATA_W-1:0] w;
    w = '0;
    unique case (rg)
      prot_pkg::REGION_BASE: begin
        w[prot_pkg::BASE_W-1:0] = s.base[en];
      end
      prot_pkg::REGION_DESC: begin
        // RULE_11 top bit and other spare bits read zero
        w[prot_pkg::DESC_KEY_LSB +: prot_pkg::KEY_W] = s.desc[en].key;
        w[prot_pkg::DESC_DIR_BIT]                    = s.desc[en].dir;
        w[prot_pkg::DESC_W_BIT]                      = s.desc[en].written;
        w[prot_pkg::DESC_LEN_LSB +: prot_pkg::LEN_W] = s.desc[en].len;
      end
      prot_pkg::REGION_STATUS: begin
        if (en == prot_pkg::STATUS_ENTRY) begin
          w[prot_pkg::STAT_EN_BIT]                         = s.enable;
          w[prot_pkg::STAT_PAGE_LSB +: prot_pkg::PAGE_W]   = s.abort_page;
          w[prot_pkg::STAT_MODE_LSB +: prot_pkg::MODE_W]   = s.abort_mode;
          w[prot_pkg::STAT_CAUSE_LSB +: prot_pkg::CAUSE_W] = s.cause;
        end
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  always_comb begin
    s_nxt = s_r;

    // one wait cycle per access; waitrequest drops for exactly one cycle
    s_nxt.waitreq = !((read || write) && s_r.waitreq);
    if (read && s_r.waitreq) begin
      s_nxt.rdata = read_word(s_r, region, entry);
    end

    // software writes at the edge where waitrequest is low
    if (accept_wr) begin
      unique case (region)
        prot_pkg::REGION_BASE: begin
          if (byteenable[0]) begin
            s_nxt.base[entry][prot_pkg::LANE_W-1:0] = writedata[prot_pkg::LANE_W-1:0];
          end
          if (byteenable[1]) begin
            s_nxt.base[entry][prot_pkg::BASE_W-1:prot_pkg::LANE_W] =
              writedata[prot_pkg::BASE_W-1:prot_pkg::LANE_W];
          end
          // RULE_09 base write clears written flag
          s_nxt.desc[entry].written = 1'b0;
        end
        prot_pkg::REGION_DESC: begin
          // RULE_01 key and RULE_07 direction are software written
          if (byteenable[0]) begin
            s_nxt.desc[entry].key = writedata[prot_pkg::DESC_KEY_LSB +: prot_pkg::KEY_W];
            s_nxt.desc[entry].dir = writedata[prot_pkg::DESC_DIR_BIT];
          end
          // RULE_10 length field written through the high byte
          if (byteenable[1]) begin
            s_nxt.desc[entry].len = writedata[prot_pkg::DESC_LEN_LSB +: prot_pkg::LEN_W];
          end
          // RULE_09 descriptor write clears written flag
          s_nxt.desc[entry].written = 1'b0;
        end
        prot_pkg::REGION_STATUS: begin
          if (entry == prot_pkg::STATUS_ENTRY) begin
            if (byteenable[0]) begin
              s_nxt.enable = writedata[prot_pkg::STAT_EN_BIT];
            end
            if (byteenable[1]) begin
              s_nxt.cause = writedata[prot_pkg::STAT_CAUSE_LSB +: prot_pkg::CAUSE_W];
            end
          end
        end
        default: begin
          s_nxt.enable = s_r.enable;
        end
      endcase
    end

    // reference path, registered one cycle toward the bus
    s_nxt.out.valid = 1'b0;
    s_nxt.out.abort = 1'b0;
    s_nxt.out.cause = '0;
    s_nxt.out.write = ref_req.write;
    if (ref_req.valid) begin
      if (!s_r.enable) begin
        // RULE_24 disabled: pass through unchecked
        s_nxt.out.valid = 1'b1;
        s_nxt.out.paddr = prot_pkg::PA_W'(ref_req.vaddr);
      end else if (flt_any) begin
        // RULE_02 aborted reference is never issued
        s_nxt.out.abort = 1'b1;
        s_nxt.out.cause = flt_vec;
        // RULE_25 causes accumulate, hardware set wins over clear
        s_nxt.cause = s_nxt.cause | flt_vec;
        if (s_r.cause == '0) begin
          s_nxt.abort_page = page;
          s_nxt.abort_mode = ref_req.mode;
        end
      end else begin
        // RULE_06 read/write key passes; RULE_22 bus sees translation
        s_nxt.out.valid = 1'b1;
        // RULE_21 offset joined below the physical block
        s_nxt.out.paddr = {pblock, voff};
        if (ref_req.write) begin
          // RULE_08 hardware marks page written, winning over a clear
          s_nxt.desc[ref_idx].written = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r         <= '0;
      s_r.waitreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- dv/prot_sva.sv ----
// assertion checker for the page relocation unit
`timescale 1ns/10ps
`default_nettype none
module prot_sva (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        srst,
  // register slave
  input wire logic [prot_pkg::ADDR_W-1:0] address,
  input wire logic                        read,
  input wire logic                        write,
  input wire logic [prot_pkg::DATA_W-1:0] writedata,
  input wire logic [prot_pkg::BE_W-1:0]   byteenable,
  input wire logic [prot_pkg::DATA_W-1:0] readdata,
  input wire logic                        waitrequest,
  // references
  input wire prot_pkg::ref_req_t          ref_req,
  input wire prot_pkg::bus_ref_t          bus_ref
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic en_r;
  // shadow of the enable bit, updated on accepted status writes
  always_ff @(posedge clk) begin
    if (srst)
      en_r <= 1'b0;
    else if (write && !waitrequest && address[7:2] == 6'h20 && byteenable[0])
      en_r <= writedata[0];
  end
  resp_once_a: assert property (ref_req.valid |=> bus_ref.valid ^ bus_ref.abort)
    else $error("reference not answered once");
  no_spurious_a: assert property (bus_ref.valid || bus_ref.abort |-> $past(ref_req.valid))
    else $error("bus reference without request");
  abort_cause_a: assert property (bus_ref.abort |-> bus_ref.cause != 3'h0)
    else $error("abort without cause");
  write_kind_a: assert property (ref_req.valid |=> bus_ref.write == $past(ref_req.write))
    else $error("write kind lost");
  pass_thru_a: assert property (ref_req.valid && !en_r |=>
    bus_ref.valid && bus_ref.paddr == {2'h0, $past(ref_req.vaddr)})
    else $error("disabled address altered");
  offset_keep_a: assert property (ref_req.valid |=>
    bus_ref.abort || bus_ref.paddr[5:0] == $past(ref_req.vaddr[5:0]))
    else $error("offset altered");
  bad_mode_a: assert property (ref_req.valid && en_r && ref_req.mode inside {2'h1, 2'h2}
    |=> bus_ref.abort && bus_ref.cause == 3'h4)
    else $error("illegal mode not aborted");
  desc_pad_a: assert property (read && !waitrequest && address[7:6] == 2'h1
    |-> readdata[31:15] == 17'h0)
    else $error("descriptor pad bits set");
  cover property (bus_ref.abort && bus_ref.cause[1]);
  cover property (ref_req.valid && !en_r);
  cover property (read && !waitrequest && address[7:6] == 2'h1);
endmodule
bind page_relocation_protection prot_sva i_prot_sva (.clk, .srst, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .ref_req, .bus_ref);
`default_nettype wire

// ---- dv/core_model.sv ----
// behavioural processor core issuing references
`timescale 1ns/10ps
`default_nettype none
module core_model (
  // clock
  input  wire logic         clk,
  // references toward the unit
  output var  prot_pkg::ref_req_t req
);
  initial req = '0;
  task automatic issue(input logic w, input logic [1:0] m, input logic [15:0] va);
    @(posedge clk);
    req.valid <= 1'b1;
    req.write <= w;
    req.mode <= m;
    req.vaddr <= va;
    @(posedge clk);
    req.valid <= 1'b0;
    req.write <= ~w;
    req.vaddr <= ~va;
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the page relocation unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %0t mismatch", $time); end end
module tb_top;
  logic               clk = 1'b0;
  logic               srst = 1'b1;
  logic [7:0]         address = 8'h00;
  logic               read = 1'b0;
  logic               write = 1'b0;
  logic [31:0]        writedata = 32'h0;
  logic [3:0]         byteenable = 4'hF;
  logic [31:0]        readdata;
  logic               waitrequest;
  logic [31:0]        rd;
  prot_pkg::ref_req_t ref_req;
  prot_pkg::bus_ref_t bus_ref;
  int                 fail_count = 0;
  int                 check_count = 0;
  always #20 clk = ~clk;
  page_relocation_protection i_page_relocation_protection (.clk, .srst, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .ref_req, .bus_ref);
  core_model i_core_model (.clk, .req(ref_req));
  function automatic logic [31:0] dsc(input logic [6:0] len, input logic dir,
                                      input logic [1:0] key);
    return {16'h0, 1'b0, len, 4'h0, dir, key, 1'b0};
  endfunction
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
  endtask
  // ab is the expected cause, zero when the reference must pass
  task automatic chk_ref(input logic w, input logic [1:0] m, input logic [15:0] va,
                         input logic [2:0] ab, input logic [17:0] pa);
    i_core_model.issue(w, m, va);
    #1;
    `CHK(bus_ref.abort, |ab)
    `CHK(bus_ref.valid, ~|ab)
    `CHK(bus_ref.write, w)
    if (ab != 3'h0)
      `CHK(bus_ref.cause, ab)
    else
      `CHK(bus_ref.paddr, pa)
  endtask
  task automatic test_regs();
    bus_rd(8'h80);
    `CHK(rd, 32'h0)
    bus_wr(8'h44, 32'hFFFF_FFFF);
    bus_rd(8'h44);
    `CHK(rd, dsc(7'h7F, 1'b1, 2'h3))
    bus_rd(8'hC4);
    `CHK(rd, 32'h0)
    chk_ref(1'b1, 2'h1, 16'hBEEF, 3'h0, 18'h0BEEF);
    $display("test_regs done");
  endtask
  task automatic test_map();
    bus_wr(8'h08, 32'h123);
    // six blocks wanted, so the length is loaded one lower
    bus_wr(8'h48, dsc(7'h05, 1'b0, 2'h3));
    bus_wr(8'h80, 32'h1);
    chk_ref(1'b1, 2'h0, {3'h2, 7'h05, 6'h2A}, 3'h0, {12'h128, 6'h2A});
    chk_ref(1'b0, 2'h0, {3'h2, 7'h06, 6'h00}, 3'h2, 18'h0);
    bus_rd(8'h80);
    `CHK(rd, 32'h0000_4005)
    bus_wr(8'h80, 32'h1);
    bus_rd(8'h48);
    `CHK(rd[6], 1'b1)
    bus_wr(8'h08, 32'h123);
    bus_rd(8'h48);
    `CHK(rd[6], 1'b0)
    // high lane only: length changes, key and direction stay
    byteenable <= 4'h2;
    bus_wr(8'h48, dsc(7'h10, 1'b1, 2'h0));
    byteenable <= 4'hF;
    bus_rd(8'h48);
    `CHK(rd, dsc(7'h10, 1'b0, 2'h3))
    $display("test_map done");
  endtask
  task automatic test_keys();
    logic [2:0] ab;
    bus_wr(8'h3C, 32'h200);
    bus_wr(8'h5C, dsc(7'h7F, 1'b0, 2'h0));
    for (int k = 0; k < 4; k++) begin
      bus_wr(8'h7C, dsc(7'h7F, 1'b0, k[1:0]));
      for (int w = 0; w < 2; w++) begin
        ab = (k[0] == 1'b0) ? 3'h4 : (k == 1 && w == 1) ? 3'h1 : 3'h0;
        chk_ref(w[0], 2'h3, 16'hE001, ab, {12'h200, 6'h01});
      end
    end
    chk_ref(1'b0, 2'h0, 16'hE001, 3'h4, 18'h0);
    chk_ref(1'b0, 2'h1, 16'hE001, 3'h4, 18'h0);
    chk_ref(1'b0, 2'h2, 16'hE001, 3'h4, 18'h0);
    // length loaded as 128 minus the 43 blocks wanted
    bus_wr(8'h7C, dsc(7'h55, 1'b1, 2'h3));
    chk_ref(1'b0, 2'h3, {3'h7, 7'h54, 6'h00}, 3'h2, 18'h0);
    chk_ref(1'b1, 2'h3, {3'h7, 7'h55, 6'h3F}, 3'h0, {12'h255, 6'h3F});
    $display("test_keys done");
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    test_regs();
    test_map();
    test_keys();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
